// *** dv/bridge_termination_translate_bench.sv ***
// Self-checking bench for the termination translator.
// Assumes the far-side model drives all event inputs.
`timescale 1ns/1ps
`default_nettype none

module bridge_termination_translate_bench;
  typedef struct packed
  {
    logic [3:0] ctrl;
    logic [1:0] kind;
    logic [1:0] term;
    logic [3:0] cls;
    logic [7:0] idx;
    logic       par;
    logic       v;
    logic [1:0] et;
    logic [8:0] st;
    logic       nmi;
    logic       serr;
  } btt_row_t;
  typedef struct packed
  {
    logic [3:0] ctrl;
    logic       ma;
    logic       ta;
    logic       run;
    logic [2:0] resp;
    logic       stop;
    logic [8:0] st;
  } btt_urow_t;
  localparam logic [31:0] DIN = 32'h1234_5678;
  // Downstream terminations and their expected effects
  localparam btt_row_t ROWS [20] = '{
    '{4'h1, 2'h0, 2'h0, 4'h0, 8'h00, 1'b1, 1'b1, 2'h0, 9'h004, 1'b0, 1'b0},
    '{4'h0, 2'h0, 2'h0, 4'h0, 8'h00, 1'b0, 1'b1, 2'h0, 9'h000, 1'b0, 1'b0},
    '{4'h1, 2'h0, 2'h1, 4'h0, 8'h00, 1'b0, 1'b1, 2'h1, 9'h001, 1'b0, 1'b0},
    '{4'h1, 2'h0, 2'h2, 4'h0, 8'h00, 1'b0, 1'b1, 2'h2, 9'h022, 1'b0, 1'b0},
    '{4'h0, 2'h1, 2'h1, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h001, 1'b0, 1'b0},
    '{4'h1, 2'h1, 2'h1, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h041, 1'b1, 1'b0},
    '{4'h4, 2'h1, 2'h2, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h042, 1'b1, 1'b0},
    '{4'h1, 2'h1, 2'h2, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h042, 1'b0, 1'b0},
    '{4'h0, 2'h2, 2'h0, 4'h0, 8'h00, 1'b1, 1'b1, 2'h0, 9'h004, 1'b0, 1'b0},
    '{4'h0, 2'h2, 2'h0, 4'h1, 8'h00, 1'b0, 1'b1, 2'h1, 9'h001, 1'b0, 1'b0},
    '{4'h1, 2'h2, 2'h0, 4'h1, 8'h01, 1'b0, 1'b1, 2'h2, 9'h022, 1'b0, 1'b0},
    '{4'h0, 2'h2, 2'h0, 4'h1, 8'h02, 1'b0, 1'b1, 2'h2, 9'h024, 1'b0, 1'b0},
    '{4'h0, 2'h2, 2'h0, 4'h2, 8'h00, 1'b0, 1'b1, 2'h2, 9'h020, 1'b0, 1'b0},
    '{4'h0, 2'h2, 2'h0, 4'h2, 8'h01, 1'b0, 1'b1, 2'h2, 9'h024, 1'b0, 1'b0},
    '{4'h0, 2'h2, 2'h0, 4'h2, 8'h85, 1'b0, 1'b1, 2'h2, 9'h020, 1'b0, 1'b0},
    '{4'h0, 2'h2, 2'h0, 4'h3, 8'h00, 1'b0, 1'b1, 2'h2, 9'h020, 1'b0, 1'b0},
    '{4'h2, 2'h3, 2'h1, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h051, 1'b0, 1'b1},
    '{4'h2, 2'h3, 2'h2, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h052, 1'b0, 1'b1},
    '{4'h0, 2'h3, 2'h1, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h011, 1'b0, 1'b0},
    '{4'h5, 2'h3, 2'h2, 4'h0, 8'h00, 1'b0, 1'b0, 2'h0, 9'h012, 1'b0, 1'b0}
  };
  // Upstream aborts of secondary-initiated cycles
  localparam btt_urow_t UROWS [5] = '{
    '{4'h0, 1'b1, 1'b0, 1'b0, btt_pkg::RESP_TA, 1'b0, 9'h088},
    '{4'h0, 1'b0, 1'b1, 1'b0, btt_pkg::RESP_TA, 1'b0, 9'h108},
    '{4'h8, 1'b1, 1'b0, 1'b0, btt_pkg::RESP_SPLIT_MA, 1'b0, 9'h080},
    '{4'h8, 1'b0, 1'b1, 1'b1, btt_pkg::RESP_SPLIT_TA, 1'b1, 9'h108},
    '{4'h8, 1'b1, 1'b1, 1'b0, btt_pkg::RESP_SPLIT_TA, 1'b0, 9'h188}
  };
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  btt_pkg::btt_dn_term_t dn_term;
  btt_pkg::btt_up_term_t up_term;
  btt_pkg::btt_up_cpl_t  up_cpl;
  btt_pkg::btt_resp_t    sec_resp;
  logic                  lock_release;
  logic                  sec_lock;
  logic                  nmi_pulse;
  logic                  serr_pulse;
  logic                  sec_connect;
  logic                  sec_stream_active;
  logic                  sc_seq_running;
  logic                  sc_seq_stop;
  logic [31:0]           rd;
  logic                  er;
  int                    mismatches;
  int                    checks;
  int                    cycles;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far side
  btt_bridge i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dn_term(dn_term),
    .lock_release(lock_release), .up_cpl(up_cpl), .sec_lock(sec_lock), .nmi_pulse(nmi_pulse),
    .serr_pulse(serr_pulse), .up_term(up_term), .sec_connect(sec_connect), .sec_stream_active(sec_stream_active),
    .sc_seq_running(sc_seq_running), .sec_resp(sec_resp), .sc_seq_stop(sc_seq_stop));
  btt_far_model i_far (.pclk(pclk), .dn_term(dn_term), .up_term(up_term), .lock_release(lock_release),
    .sec_connect(sec_connect), .sec_stream_active(sec_stream_active), .sc_seq_running(sc_seq_running));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
  begin
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  end
  endtask

  // Final report
  task automatic print_verdict();
  begin
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, btt_pkg::ADDR_STAT, 32'h0000_0000);
    chk(rd, {23'h00_0000, btt_pkg::STAT_RESET}, "status after reset");
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk(er, 1'b1, "unmapped write error");
    apb(1'b0, btt_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(rd, {28'h000_0000, btt_pkg::CTRL_RESET}, "control untouched");
    foreach (ROWS[i])
    begin
      apb(1'b1, btt_pkg::ADDR_CTRL, {28'h000_0000, ROWS[i].ctrl});
      i_far.send_dn('{1'b1, btt_pkg::btt_kind_t'(ROWS[i].kind), btt_pkg::btt_term_t'(ROWS[i].term),
        ROWS[i].cls, ROWS[i].idx, ROWS[i].par, 1'b1, 1'b1, DIN});
      #1;
      chk(up_cpl.valid, ROWS[i].v, "completion valid");
      if (ROWS[i].v === 1'b1)
      begin
        chk(up_cpl.term, ROWS[i].et, "completion code");
        chk(up_cpl.data, (ROWS[i].et == 2'h0) ? DIN : btt_pkg::DATA_ALL_ONES, "completion data");
        chk(sec_lock, {31'h0, ROWS[i].et == 2'h0}, "bus lock after completion");
      end
      chk(nmi_pulse, ROWS[i].nmi, "nmi request");
      chk(serr_pulse, ROWS[i].serr, "serr request");
      apb(1'b0, btt_pkg::ADDR_STAT, 32'h0000_0000);
      chk(rd, {23'h00_0000, ROWS[i].st}, "status bits");
      apb(1'b1, btt_pkg::ADDR_STAT, 32'h0000_01FF);
    end
    foreach (UROWS[i])
    begin
      apb(1'b1, btt_pkg::ADDR_CTRL, {28'h000_0000, UROWS[i].ctrl});
      i_far.send_up(UROWS[i].ma, UROWS[i].ta, UROWS[i].run);
      #1;
      if (UROWS[i].ctrl[btt_pkg::CTL_PCIX] === 1'b0)
      begin
        chk(sec_resp, btt_pkg::RESP_NONE, "response before connect");
        i_far.pulse_connect();
        #1;
      end
      chk(sec_resp, UROWS[i].resp, "secondary response");
      chk(sc_seq_stop, UROWS[i].stop, "sequence stop");
      apb(1'b0, btt_pkg::ADDR_STAT, 32'h0000_0000);
      chk(rd, {23'h00_0000, UROWS[i].st}, "inbound status");
      apb(1'b1, btt_pkg::ADDR_STAT, 32'h0000_01FF);
    end
    // Locked success holds the bus until the far side releases it
    i_far.send_dn('{1'b1, btt_pkg::KIND_IMM_CPL, btt_pkg::TERM_OK, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1, DIN});
    #1;
    chk(sec_lock, 1'b1, "bus locked after success");
    apb(1'b0, btt_pkg::ADDR_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_0009, "state readback");
    i_far.release_lock();
    #1;
    chk(sec_lock, 1'b0, "bus released after release pulse");
    // Reset in mid-run clears sticky status and control
    apb(1'b1, btt_pkg::ADDR_CTRL, 32'h0000_000F);
    i_far.send_dn('{1'b1, btt_pkg::KIND_POSTED, btt_pkg::TERM_MA, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0, DIN});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, btt_pkg::ADDR_STAT, 32'h0000_0000);
    chk(rd, {23'h00_0000, btt_pkg::STAT_RESET}, "status after second reset");
    apb(1'b0, btt_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(rd, {28'h000_0000, btt_pkg::CTRL_RESET}, "control after second reset");
    print_verdict();
  end
endmodule

`default_nettype wire

// *** dv/btt_far_model.sv ***
// Far-side model: upstream link and secondary bus agents.
// Assumes its tasks are called from the bench's main process.
`timescale 1ns/1ps
`default_nettype none

module btt_far_model
(
  // Clock
  input  wire logic                 pclk,
  // Events towards the bridge
  output var btt_pkg::btt_dn_term_t dn_term,
  output var btt_pkg::btt_up_term_t up_term,
  output var logic                  lock_release,
  output var logic                  sec_connect,
  output var logic                  sec_stream_active,
  output var logic                  sc_seq_running
);
  ////////////////////////////////////////////////////////////////////////////
  // Quiet lines at time zero
  initial
  begin
    dn_term = '0;
    up_term = '0;
    lock_release = 1'b0;
    sec_connect = 1'b0;
    sec_stream_active = 1'b0;
    sc_seq_running = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle downstream termination; stale fields scrambled afterwards
  task automatic send_dn(input btt_pkg::btt_dn_term_t ev);
  begin
    @(posedge pclk);
    dn_term <= ev;
    @(posedge pclk);
    dn_term <= btt_pkg::btt_dn_term_t'({1'b0, ~ev[$bits(ev)-2:0]});
  end
  endtask

  // One-cycle upstream abort report, with stream levels
  task automatic send_up(input logic ma, input logic ta, input logic run);
  begin
    @(posedge pclk);
    up_term <= '{1'b1, ma, ta};
    sc_seq_running <= run;
    sec_stream_active <= 1'b1;
    @(posedge pclk);
    up_term <= '{1'b0, ~ma, ~ta};
  end
  endtask

  // One-cycle release of a held secondary lock
  task automatic release_lock();
  begin
    @(posedge pclk);
    lock_release <= 1'b1;
    @(posedge pclk);
    lock_release <= 1'b0;
  end
  endtask

  // Connect or reconnect of a secondary master
  task automatic pulse_connect();
  begin
    @(posedge pclk);
    sec_connect <= 1'b1;
    @(posedge pclk);
    sec_connect <= 1'b0;
  end
  endtask
endmodule

`default_nettype wire

// *** include/btt_pkg.sv ***
// Package for the bridge termination translator.
// Holds register offsets, field positions, reset values and the
// enumerations shared by the design and its bench.
package btt_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_STAT  = 12'h004;
  localparam logic [11:0] ADDR_STATE = 12'h008;

  // Control register fields
  localparam int          CTL_ABORT_MODE = 0;
  localparam int          CTL_SERR_EN    = 1;
  localparam int          CTL_NMI_EN     = 2;
  localparam int          CTL_PCIX       = 3;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;

  // Status register fields, write one to clear
  localparam int          ST_SEC_RMA  = 0;
  localparam int          ST_SEC_RTA  = 1;
  localparam int          ST_SEC_MDPE = 2;
  localparam int          ST_SEC_STA  = 3;
  localparam int          ST_SEC_SCD  = 4;
  localparam int          ST_PRI_STA  = 5;
  localparam int          ST_PRI_SSE  = 6;
  localparam int          ST_PRI_RMA  = 7;
  localparam int          ST_PRI_RTA  = 8;
  localparam int          ST_WIDTH    = 9;
  localparam logic [8:0]  STAT_RESET  = 9'h000;

  // Split completion message codes
  localparam logic [3:0]  MSG_CLASS_OK  = 4'h0;
  localparam logic [3:0]  MSG_CLASS_CPL = 4'h1;
  localparam logic [3:0]  MSG_CLASS_BRG = 4'h2;
  localparam logic [7:0]  MSG_IDX_00    = 8'h00;
  localparam logic [7:0]  MSG_IDX_01    = 8'h01;
  localparam logic [7:0]  MSG_IDX_02    = 8'h02;
  localparam logic [7:0]  MSG_DEV_MASK  = 8'hF0;
  localparam logic [7:0]  MSG_DEV_CODE  = 8'h80;

  // Read data: all ones returned for aborted reads, zero for unmapped or idle reads
  localparam logic [31:0] DATA_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

  // Termination seen on a bus
  typedef enum logic [1:0]
  {
    TERM_OK = 2'b00,
    TERM_MA = 2'b01,
    TERM_TA = 2'b10
  } btt_term_t;

  // Kind of downstream termination event
  typedef enum logic [1:0]
  {
    KIND_IMM_CPL   = 2'b00,
    KIND_POSTED    = 2'b01,
    KIND_SPLIT_MSG = 2'b10,
    KIND_SC_OUT    = 2'b11
  } btt_kind_t;

  // Response given to a secondary master
  typedef enum logic [2:0]
  {
    RESP_NONE     = 3'b000,
    RESP_OK       = 3'b001,
    RESP_TA       = 3'b010,
    RESP_SPLIT_MA = 3'b011,
    RESP_SPLIT_TA = 3'b100
  } btt_resp_t;

  // Inbound abort tracking
  typedef enum logic [0:0]
  {
    IN_IDLE = 1'b0,
    IN_PEND = 1'b1
  } btt_in_state_t;

  // Termination of an upstream-initiated cycle on the secondary bus
  typedef struct packed
  {
    logic        valid;
    btt_kind_t   kind;
    btt_term_t   term;
    logic [3:0]  msg_class;
    logic [7:0]  msg_index;
    logic        parity_err;
    logic        is_read;
    logic        locked;
    logic [31:0] data;
  } btt_dn_term_t;

  // Completion returned to the upstream link
  typedef struct packed
  {
    logic        valid;
    btt_term_t   term;
    logic [31:0] data;
  } btt_up_cpl_t;

  // Termination of a secondary-initiated cycle on the upstream link
  typedef struct packed
  {
    logic valid;
    logic ma;
    logic ta;
  } btt_up_term_t;

endpackage

// *** rtl/btt_bridge.sv ***
// Bridge termination translator: maps terminations between the
// upstream link and the secondary PCI / PCI-X bus, sets status bits
// and raises NMI/SMI and SERR# pulses.
// Assumes one clock, event inputs synchronous to pclk, and an APB
// master on the register port.
//
// Summary of operation
// - Aborted immediate completion-required reads return all-ones data upstream.
// - Immediate success, master abort, target abort pass upstream unchanged.
// - Immediate abort sets secondary received abort bits; target abort sets primary signaled.
// - Secondary data parity bit set only on a secondary data parity error.
// - Posted write master abort: NMI and system error only with abort mode one.
// - Posted write target abort: NMI as enabled, received abort and system error.
// - Split-terminated aborted reads return all-ones on every byte.
// - Any abort returned upstream leaves the secondary bus unlocked.
// - Class 0 index 00h completes successfully; parity bit on parity error.
// - Class 1 indices map to master abort or target abort with status bits.
// - Class 2 and illegal messages give target abort and primary signaled abort.
// - Outbound split completion master abort sets three bits and gated SERR#.
// - Outbound split completion target abort sets three bits and gated SERR#.
// - SERR# and system error bit for failed split completions need SERR enable.
// - PCI mode upstream master abort becomes target abort, sets two bits.
// - Upstream target abort becomes target abort or split target abort.
// - Upstream master and target abort together give target abort or split target abort, three bits.
// - PCI mode target abort only at connect or reconnect, never mid-stream.
// - PCI-X mode abort gives split error message; master abort sets primary bit only.
// - A running PCI-X completion sequence is stopped when an abort arrives.

`timescale 1ns/1ps
`default_nettype none

module btt_bridge
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Upstream-initiated cycles
  input  wire btt_pkg::btt_dn_term_t dn_term,
  input  wire logic                  lock_release,
  output btt_pkg::btt_up_cpl_t       up_cpl,
  output logic                       sec_lock,
  output logic                       nmi_pulse,
  output logic                       serr_pulse,
  // Secondary-initiated cycles
  input  wire btt_pkg::btt_up_term_t up_term,
  input  wire logic                  sec_connect,
  input  wire logic                  sec_stream_active,
  input  wire logic                  sc_seq_running,
  output btt_pkg::btt_resp_t         sec_resp,
  output logic                       sc_seq_stop
);

  ////////////////////////////////////////////////////////////////////
  // Split message decoding

  // Upstream result of a split completion message
  function automatic btt_pkg::btt_term_t btt_msg_term(input logic [3:0] cls, input logic [7:0] idx);
    btt_pkg::btt_term_t t;
    t = btt_pkg::TERM_TA;
    if (cls == btt_pkg::MSG_CLASS_OK && idx == btt_pkg::MSG_IDX_00)
      t = btt_pkg::TERM_OK;
    else if (cls == btt_pkg::MSG_CLASS_CPL && idx == btt_pkg::MSG_IDX_00)
      t = btt_pkg::TERM_MA;
    return t;
  endfunction

  // Index is a data parity message
  function automatic logic btt_msg_parity(input logic [3:0] cls, input logic [7:0] idx);
    return (cls == btt_pkg::MSG_CLASS_CPL && idx == btt_pkg::MSG_IDX_02) ||
           (cls == btt_pkg::MSG_CLASS_BRG && idx == btt_pkg::MSG_IDX_01);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic [3:0]                  ctrl;
  logic [btt_pkg::ST_WIDTH-1:0] stat;
  btt_pkg::btt_in_state_t      in_state;
  btt_pkg::btt_in_state_t      next_in_state;
  logic                        pend_ma;
  logic                        pend_ta;

  wire abort_mode = ctrl[btt_pkg::CTL_ABORT_MODE];
  wire serr_en    = ctrl[btt_pkg::CTL_SERR_EN];
  wire nmi_en     = ctrl[btt_pkg::CTL_NMI_EN];
  wire pcix_mode  = ctrl[btt_pkg::CTL_PCIX];

  ////////////////////////////////////////////////////////////////////
  // APB decode

  wire apb_setup  = psel && !penable && !pready;
  wire apb_done   = psel && penable && pready;
  wire hit_ctrl   = paddr == btt_pkg::ADDR_CTRL;
  wire hit_stat   = paddr == btt_pkg::ADDR_STAT;
  wire hit_state  = paddr == btt_pkg::ADDR_STATE;
  wire hit_any    = hit_ctrl || hit_stat || hit_state;
  wire wr_ctrl    = apb_done && pwrite && hit_ctrl;
  wire wr_stat    = apb_done && pwrite && hit_stat;
  wire [btt_pkg::ST_WIDTH-1:0] stat_clr = wr_stat ? pwdata[btt_pkg::ST_WIDTH-1:0] : '0;

  // Read data selection
  wire [31:0] rd_data = hit_ctrl  ? {28'h000_0000, ctrl} :
                        hit_stat  ? {23'h00_0000, stat} :
                        hit_state ? {28'h000_0000, pend_ta, pend_ma, in_state, sec_lock} :
                                    btt_pkg::DATA_ZERO;

  ////////////////////////////////////////////////////////////////////
  // Downstream termination decode

  wire dn_v     = dn_term.valid;
  wire k_imm    = dn_v && dn_term.kind == btt_pkg::KIND_IMM_CPL;
  wire k_post   = dn_v && dn_term.kind == btt_pkg::KIND_POSTED;
  wire k_msg    = dn_v && dn_term.kind == btt_pkg::KIND_SPLIT_MSG;
  wire k_sc     = dn_v && dn_term.kind == btt_pkg::KIND_SC_OUT;
  wire t_ma     = dn_term.term == btt_pkg::TERM_MA;
  wire t_ta     = dn_term.term == btt_pkg::TERM_TA;
  wire btt_pkg::btt_term_t msg_term = btt_msg_term(dn_term.msg_class, dn_term.msg_index);
  wire msg_par  = btt_msg_parity(dn_term.msg_class, dn_term.msg_index);

  // Result returned upstream, unchanged for immediate cycles
  wire btt_pkg::btt_term_t cpl_term = k_msg ? msg_term : dn_term.term;
  wire cpl_abort = cpl_term != btt_pkg::TERM_OK;
  wire cpl_fire  = k_imm || k_msg;

  // Aborted reads return all ones
  wire [31:0] cpl_data = (dn_term.is_read && cpl_abort) ? btt_pkg::DATA_ALL_ONES : dn_term.data;

  // Posted write and outbound split completion side effects
  wire post_nmi = k_post && ((t_ma && abort_mode) || (t_ta && nmi_en));
  wire post_sse = k_post && ((t_ma && abort_mode) || t_ta);
  wire sc_fail  = k_sc && (t_ma || t_ta);
  wire sc_serr  = sc_fail && serr_en;

  ////////////////////////////////////////////////////////////////////
  // Inbound decode

  wire in_v      = up_term.valid && (up_term.ma || up_term.ta);
  wire in_ok     = up_term.valid && !up_term.ma && !up_term.ta;
  // PCI-X response: target abort wins when both are reported
  wire btt_pkg::btt_resp_t pcix_resp = up_term.ta ? btt_pkg::RESP_SPLIT_TA : btt_pkg::RESP_SPLIT_MA;
  // PCI signals a pending abort at a connect or reconnect
  wire pci_fire  = in_state == btt_pkg::IN_PEND && sec_connect && !pcix_mode;

  // Inbound state
  always_comb
  begin
    next_in_state = in_state;
    unique case (in_state)
      btt_pkg::IN_IDLE:
        if (in_v && !pcix_mode)
          next_in_state = btt_pkg::IN_PEND;
      btt_pkg::IN_PEND:
        if (pci_fire || pcix_mode)
          next_in_state = btt_pkg::IN_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Status set terms

  logic [btt_pkg::ST_WIDTH-1:0] stat_set;
  always_comb
  begin
    stat_set = '0;
    // Downstream terminations: immediate, split message, posted write and outbound split completion
    stat_set[btt_pkg::ST_SEC_RMA] = (k_imm && t_ma) || (k_msg && msg_term == btt_pkg::TERM_MA) ||
                                    (k_post && t_ma) || (k_sc && t_ma);
    stat_set[btt_pkg::ST_SEC_RTA] = (k_imm && t_ta) || (k_post && t_ta) || (k_sc && t_ta) ||
                                    (k_msg && dn_term.msg_class == btt_pkg::MSG_CLASS_CPL &&
                                     dn_term.msg_index == btt_pkg::MSG_IDX_01);
    stat_set[btt_pkg::ST_PRI_STA] = (k_imm && t_ta) || (k_msg && msg_term == btt_pkg::TERM_TA);
    // Parity bit only on a real secondary parity error
    stat_set[btt_pkg::ST_SEC_MDPE] = ((k_imm || k_msg) && dn_term.parity_err) || (k_msg && msg_par);
    stat_set[btt_pkg::ST_SEC_SCD] = sc_fail;
    stat_set[btt_pkg::ST_PRI_SSE] = post_sse || sc_serr;
    // Secondary-initiated cycles
    stat_set[btt_pkg::ST_PRI_RMA] = in_v && up_term.ma;
    stat_set[btt_pkg::ST_PRI_RTA] = in_v && up_term.ta;
    stat_set[btt_pkg::ST_SEC_STA] = in_v && (up_term.ta || !pcix_mode);
  end

  ////////////////////////////////////////////////////////////////////
  // Register file and APB answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= btt_pkg::CTRL_RESET;
      stat    <= btt_pkg::STAT_RESET;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= btt_pkg::DATA_ZERO;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= pwdata[3:0];
      stat    <= (stat & ~stat_clr) | stat_set; // Set beats clear
      pready  <= apb_setup;
      pslverr <= apb_setup && !hit_any;
      prdata  <= (apb_setup && !pwrite) ? rd_data : btt_pkg::DATA_ZERO;
    end
  end

  // Upstream completion, lock and pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_cpl     <= '0;
      sec_lock   <= 1'b0;
      nmi_pulse  <= 1'b0;
      serr_pulse <= 1'b0;
    end
    else
    begin
      up_cpl.valid <= cpl_fire;
      up_cpl.term  <= cpl_fire ? cpl_term : btt_pkg::TERM_OK;
      up_cpl.data  <= cpl_fire ? cpl_data : btt_pkg::DATA_ZERO;
      if (cpl_fire)
        sec_lock <= dn_term.locked && !cpl_abort;
      else if (lock_release)
        sec_lock <= 1'b0;
      nmi_pulse  <= post_nmi;
      serr_pulse <= sc_serr;
    end
  end

  // Inbound abort tracking and secondary response
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_state    <= btt_pkg::IN_IDLE;
      pend_ma     <= 1'b0;
      pend_ta     <= 1'b0;
      sec_resp    <= btt_pkg::RESP_NONE;
      sc_seq_stop <= 1'b0;
    end
    else
    begin
      in_state <= next_in_state;
      if (in_v && !pcix_mode)
      begin
        pend_ma <= up_term.ma;
        pend_ta <= up_term.ta;
      end
      if (in_v && pcix_mode)
        sec_resp <= pcix_resp;
      else if (pci_fire)
        sec_resp <= btt_pkg::RESP_TA;
      else if (in_ok)
        sec_resp <= btt_pkg::RESP_OK;
      else
        sec_resp <= btt_pkg::RESP_NONE;
      sc_seq_stop <= in_v && pcix_mode && sc_seq_running;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_imm_read_abort;
    k_imm && dn_term.is_read && (t_ma || t_ta);
  endsequence

  sequence s_pci_abort_then_connect;
    (in_v && !pcix_mode) ##1 (!sec_connect && !pcix_mode) ##1 (sec_connect && !pcix_mode);
  endsequence

  AST_ALL_ONES_IMM: assert property (@(posedge pclk) disable iff (!presetn)
    s_imm_read_abort |=> up_cpl.valid && up_cpl.data == btt_pkg::DATA_ALL_ONES)
    else $error("aborted read did not return all ones");

  AST_TERM_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    k_imm |=> up_cpl.valid && up_cpl.term == $past(dn_term.term))
    else $error("immediate termination not passed upstream unchanged");

  AST_POSTED_MA_MODE0: assert property (@(posedge pclk) disable iff (!presetn)
    (k_post && t_ma && !abort_mode && !wr_stat) |=> !nmi_pulse && stat[btt_pkg::ST_SEC_RMA])
    else $error("posted master abort with mode zero misbehaved");

  AST_POSTED_TA: assert property (@(posedge pclk) disable iff (!presetn)
    (k_post && t_ta && !wr_stat) |=> stat[btt_pkg::ST_PRI_SSE] && stat[btt_pkg::ST_SEC_RTA] &&
                                     nmi_pulse == $past(nmi_en))
    else $error("posted target abort status or NMI wrong");

  AST_UNLOCK_ON_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    (cpl_fire && cpl_abort) |=> !sec_lock && up_cpl.term != btt_pkg::TERM_OK)
    else $error("bus left locked after abort upstream");

  AST_MSG_CLASS2: assert property (@(posedge pclk) disable iff (!presetn)
    (k_msg && dn_term.msg_class == btt_pkg::MSG_CLASS_BRG) |=> up_cpl.term == btt_pkg::TERM_TA)
    else $error("class two message not a target abort");

  AST_SERR_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    serr_pulse |-> $past(serr_en) && $past(sc_fail))
    else $error("SERR pulse without enable or failure");

  AST_PCI_TA_AT_CONNECT: assert property (@(posedge pclk) disable iff (!presetn)
    s_pci_abort_then_connect |=> sec_resp == btt_pkg::RESP_TA)
    else $error("pending abort not signalled at connect");

  AST_PCI_NO_MIDSTREAM: assert property (@(posedge pclk) disable iff (!presetn)
    (!pcix_mode && !sec_connect && !(in_v && pcix_mode)) |=> sec_resp != btt_pkg::RESP_TA)
    else $error("target abort outside a connect");

  AST_SEQ_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (in_v && pcix_mode && sc_seq_running) |=> sc_seq_stop ##1 !sc_seq_stop)
    else $error("running completion sequence not stopped once");

endmodule

`default_nettype wire
